// File: ldrb_pkg.sv
package ldrb_pkg;

  // ---------------------------------------------------------------
  // Command addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_NOP        = 8'h00;
  localparam logic [7:0] CMD_CODE_WR    = 8'h01;
  localparam logic [7:0] CMD_READ       = 8'h02;
  localparam logic [7:0] CMD_CONTROL_WR = 8'h55;
  localparam logic [7:0] CMD_SOFT_RST   = 8'h56;
  localparam logic [7:0] CMD_CONFIG_WR  = 8'h57;
  localparam logic [7:0] CMD_GAIN_WR    = 8'h58;
  localparam logic [7:0] CMD_ZERO_WR    = 8'h59;
  localparam logic [7:0] CMD_WDOG_KICK  = 8'h95;

  // ---------------------------------------------------------------
  // Read selectors (data bits 5:0 of a read frame)
  // ---------------------------------------------------------------
  localparam logic [1:0] RSEL_STATUS  = 2'h0;
  localparam logic [1:0] RSEL_CODE    = 2'h1;
  localparam logic [1:0] RSEL_CONTROL = 2'h2;
  localparam logic [5:0] RSEL_CONFIG  = 6'h0b;
  localparam logic [5:0] RSEL_GAIN    = 6'h13;
  localparam logic [5:0] RSEL_ZERO    = 6'h17;

  // ---------------------------------------------------------------
  // Field positions and masks
  // ---------------------------------------------------------------
  localparam int          SOFT_RST_BIT    = 0;
  localparam logic [15:0] CONFIG_WR_MASK  = 16'h07bf;
  localparam logic [15:0] STATUS_RD_MASK  = 16'h001f;
  localparam logic [15:0] RESET_VALUE     = 16'h0000;
  localparam int          CODE_BITS_FULL  = 16;

  // ---------------------------------------------------------------
  // Range codes and clear values
  // ---------------------------------------------------------------
  localparam logic [2:0]  RANGE_BIPOLAR_5  = 3'h2;
  localparam logic [2:0]  RANGE_BIPOLAR_10 = 3'h3;
  localparam logic [2:0]  RANGE_4_TO_20    = 3'h5;
  localparam int          RANGE_CURRENT_BIT = 2;
  localparam logic [15:0] CODE_ZERO_SCALE  = 16'h0000;
  localparam logic [15:0] CODE_MID_SCALE   = 16'h8000;
  localparam int          SYNC_STAGES      = 3;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic       clear_value_select;
    logic       overrange_enable;
    logic       external_resistor_enable;
    logic       output_drive_enable;
    logic [3:0] slew_clock_select;
    logic [2:0] slew_step_select;
    logic       slew_limit_enable;
    logic       chain_mode_enable;
    logic [2:0] range;
  } ldrb_control_type;

  typedef struct packed {
    logic [4:0] reserved_hi;
    logic [1:0] current_only_range;
    logic       both_outputs_enable;
    logic       alternate_powerdown;
    logic       reserved_lo;
    logic       user_trim_enable;
    logic       modulation_input_enable;
    logic       frame_check_enable;
    logic       watchdog_enable;
    logic [1:0] watchdog_period;
  } ldrb_config_type;

  typedef struct packed {
    logic [10:0] reserved;
    logic        frame_check_fault;
    logic        watchdog_fault;
    logic        current_loop_fault;
    logic        slewing_active;
    logic        overtemp_fault;
  } ldrb_status_type;

  typedef struct packed {
    logic [7:0]  addr;
    logic [15:0] data;
  } ldrb_frame_type;

  typedef struct packed {
    logic       voltage_output_enable;
    logic       current_output_enable;
    logic [2:0] voltage_range;
    logic [2:0] current_range;
    logic       overrange_enable;
    logic       external_resistor_enable;
    logic       alternate_powerdown;
    logic       modulation_input_connect;
    logic       slew_limit_enable;
    logic [3:0] slew_clock_select;
    logic [2:0] slew_step_select;
  } ldrb_analog_type;

  typedef struct packed {
    logic       chain_mode_enable;
    logic       frame_check_enable;
    logic       watchdog_enable;
    logic [1:0] watchdog_period;
  } ldrb_serial_type;

endpackage

// File: ldrb_register_bank.sv
`timescale 1ns/1ps

module ldrb_register_bank #(
  parameter int CODE_BITS = ldrb_pkg::CODE_BITS_FULL
) (
  input  wire logic                     clock,
  input  wire logic                     sys_rst,
  input  wire logic                     frame_valid,
  input  wire ldrb_pkg::ldrb_frame_type frame,
  input  wire logic                     clear_value_pin,
  input  wire logic                     clear_request_pin,
  input  wire logic                     overtemp_pin,
  input  wire logic                     current_loop_pin,
  input  wire logic                     frame_check_error,
  input  wire logic                     watchdog_timeout,
  input  wire logic                     slewing_active,
  output logic [15:0]                   read_word,
  output logic                          read_word_valid,
  output logic                          watchdog_kick,
  output logic [15:0]                   output_code,
  output ldrb_pkg::ldrb_analog_type     analog_ctrl,
  output ldrb_pkg::ldrb_serial_type     serial_ctrl
);

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  localparam int NPIN = 4;
  localparam logic [15:0] CODE_MASK =
    16'hffff << (ldrb_pkg::CODE_BITS_FULL - CODE_BITS);

  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] sync_reg [ldrb_pkg::SYNC_STAGES];
  logic [NPIN-1:0] sync_next [ldrb_pkg::SYNC_STAGES];
  logic [NPIN-1:0] pin_level_reg;
  logic [NPIN-1:0] pin_level_next;

  // All four pins are asynchronous to the clock
  assign pin_raw = {clear_request_pin, clear_value_pin, current_loop_pin, overtemp_pin};

  always_comb begin
    sync_next[0] = pin_raw;
    for (int i = 1; i < ldrb_pkg::SYNC_STAGES; i++) begin
      sync_next[i] = sync_reg[i-1];
    end
    // A change counts only once the last two stages agree
    pin_level_next = pin_level_reg;
    for (int b = 0; b < NPIN; b++) begin
      if (sync_reg[1][b] == sync_reg[2][b]) begin
        pin_level_next[b] = sync_reg[2][b];
      end
    end
  end

  // Soft reset leaves the pin levels alone: they describe the outside world
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      for (int i = 0; i < ldrb_pkg::SYNC_STAGES; i++) begin
        sync_reg[i] <= '0;
      end
      pin_level_reg <= '0;
    end else begin
      sync_reg      <= sync_next;
      pin_level_reg <= pin_level_next;
    end
  end

  logic overtemp_level;
  logic loop_level;
  logic clear_pin_level;
  logic clear_request_level;

  assign overtemp_level      = pin_level_reg[0];
  assign loop_level          = pin_level_reg[1];
  assign clear_pin_level     = pin_level_reg[2];
  assign clear_request_level = pin_level_reg[3];

  // ---------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------
  ldrb_pkg::ldrb_control_type control_reg;
  ldrb_pkg::ldrb_control_type control_next;
  ldrb_pkg::ldrb_config_type  config_reg;
  ldrb_pkg::ldrb_config_type  config_next;
  logic [15:0]                code_reg;
  logic [15:0]                code_next;
  logic [15:0]                gain_reg;
  logic [15:0]                gain_next;
  logic [15:0]                zero_reg;
  logic [15:0]                zero_next;
  logic                       soft_reset_reg;
  logic                       soft_reset_next;
  logic [15:0]                read_word_reg;
  logic [15:0]                read_word_next;
  logic                       read_valid_reg;
  logic                       read_valid_next;
  logic                       kick_reg;
  logic                       kick_next;
  ldrb_pkg::ldrb_status_type  status_reg;
  ldrb_pkg::ldrb_status_type  status_next;

  ldrb_pkg::ldrb_control_type control_wr;
  logic                       clear_select;
  logic [15:0]                clear_code;
  logic [7:0]                 addr;
  logic [15:0]                data;

  assign addr = frame.addr;
  assign data = frame.data;

  // Clear code under a given range; pin or bit swaps the voltage-range clear value between zero and midscale
  function automatic logic [15:0] clear_code_for(input logic [2:0] rng, input logic sel);
    logic bipolar;
    bipolar = (rng == ldrb_pkg::RANGE_BIPOLAR_5) || (rng == ldrb_pkg::RANGE_BIPOLAR_10);
    // clear value select
    // Current ranges always clear to the low end
    if (rng[ldrb_pkg::RANGE_CURRENT_BIT]) begin
      clear_code_for = ldrb_pkg::CODE_ZERO_SCALE;
    end else if (sel) begin
      clear_code_for = bipolar ? ldrb_pkg::CODE_ZERO_SCALE : ldrb_pkg::CODE_MID_SCALE;
    end else begin
      clear_code_for = bipolar ? ldrb_pkg::CODE_MID_SCALE : ldrb_pkg::CODE_ZERO_SCALE;
    end
  endfunction

  always_comb begin
    control_wr   = ldrb_pkg::ldrb_control_type'(data);
    clear_select = control_reg.clear_value_select | clear_pin_level;
    clear_code   = clear_code_for(control_reg.range, clear_select);

    control_next    = control_reg;
    config_next     = config_reg;
    code_next       = code_reg;
    gain_next       = gain_reg;
    zero_next       = zero_reg;
    soft_reset_next = 1'b0;
    read_word_next  = read_word_reg;
    read_valid_next = read_valid_reg;
    kick_next       = 1'b0;

    // Clear pin holds the code at the clear value while high
    if (clear_request_level) begin
      code_next = clear_code;
    end

    if (frame_valid) begin
      // Readback only lives for the frame after the read command
      read_valid_next = 1'b0;
      case (addr)
        ldrb_pkg::CMD_CONTROL_WR: begin
          control_next = control_wr;
          if (control_wr.range != control_reg.range) begin
            code_next = clear_code_for(control_wr.range,
                                       control_wr.clear_value_select | clear_pin_level);
          end
        end
        // configuration write; reserved bits kept zero; no code clear
        ldrb_pkg::CMD_CONFIG_WR: begin
          config_next = ldrb_pkg::ldrb_config_type'(data & ldrb_pkg::CONFIG_WR_MASK);
        end
        // code and trim writes; low bits dropped in narrow variant
        ldrb_pkg::CMD_CODE_WR: begin
          // Dropped, not queued, while a clear request holds
          if (!clear_request_level) begin
            code_next = data & CODE_MASK;
          end
        end
        ldrb_pkg::CMD_GAIN_WR: begin
          gain_next = data & CODE_MASK;
        end
        ldrb_pkg::CMD_ZERO_WR: begin
          zero_next = data & CODE_MASK;
        end
        // soft reset request, upper bits ignored
        ldrb_pkg::CMD_SOFT_RST: begin
          soft_reset_next = data[ldrb_pkg::SOFT_RST_BIT];
        end
        // read command captures the selected register
        ldrb_pkg::CMD_READ: begin
          read_valid_next = 1'b1;
          if (data[5:0] == ldrb_pkg::RSEL_CONFIG) begin
            read_word_next = 16'(config_reg);
          end else if (data[5:0] == ldrb_pkg::RSEL_GAIN) begin
            read_word_next = gain_reg;
          end else if (data[5:0] == ldrb_pkg::RSEL_ZERO) begin
            read_word_next = zero_reg;
          end else begin
            case (data[1:0])
              ldrb_pkg::RSEL_STATUS:  read_word_next = 16'(status_reg) & ldrb_pkg::STATUS_RD_MASK;
              ldrb_pkg::RSEL_CODE:    read_word_next = code_reg;
              ldrb_pkg::RSEL_CONTROL: read_word_next = 16'(control_reg);
              // Selectors with both low bits set, other than config, gain and zero, read zero
              default:                read_word_next = ldrb_pkg::RESET_VALUE;
            endcase
          end
        end
        // Padding frame behind a read only retires the readback
        ldrb_pkg::CMD_NOP: begin
          read_valid_next = 1'b0;
        end
        ldrb_pkg::CMD_WDOG_KICK: begin
          kick_next = 1'b1;
        end
        default: begin
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Alarm status
  // ---------------------------------------------------------------
  always_comb begin
    // Reserved bits stay zero through this default
    status_next = '0;
    // alarms follow causes; fault positions
    // Checker, watchdog and ramp share this clock: no synchroniser
    status_next.frame_check_fault  = frame_check_error;
    status_next.watchdog_fault     = watchdog_timeout;
    status_next.current_loop_fault = loop_level;
    status_next.overtemp_fault     = overtemp_level;
    status_next.slewing_active     = slewing_active;
  end

  always_ff @(posedge clock) begin
    // Soft reset acts a cycle after its frame; the frame behind it is lost
    // software reset returns every register of this block to defaults except the pin synchronisers and the output stage
    if (sys_rst || soft_reset_reg) begin
      control_reg    <= '0;
      config_reg     <= '0;
      // code and trims reset to zero
      code_reg       <= ldrb_pkg::RESET_VALUE;
      gain_reg       <= ldrb_pkg::RESET_VALUE;
      zero_reg       <= ldrb_pkg::RESET_VALUE;
      read_word_reg  <= ldrb_pkg::RESET_VALUE;
      read_valid_reg <= 1'b0;
      kick_reg       <= 1'b0;
      status_reg     <= '0;
      soft_reset_reg <= 1'b0;
    end else begin
      control_reg    <= control_next;
      config_reg     <= config_next;
      code_reg       <= code_next;
      gain_reg       <= gain_next;
      zero_reg       <= zero_next;
      read_word_reg  <= read_word_next;
      read_valid_reg <= read_valid_next;
      kick_reg       <= kick_next;
      status_reg     <= status_next;
      soft_reset_reg <= soft_reset_next;
    end
  end

  // ---------------------------------------------------------------
  // Trimmed code
  // ---------------------------------------------------------------
  logic [31:0]        gain_product;
  logic signed [17:0] trimmed;
  logic [15:0]        code_out_next;
  logic [15:0]        code_out_reg;

  always_comb begin
    gain_product = code_reg * gain_reg;
    trimmed = $signed({2'b00, gain_product[31:16]}) + $signed({{2{zero_reg[15]}}, zero_reg});
    // Saturate, not wrap: a wrapped code would swing the output end to end
    // trim applied only when enabled; result saturates
    if (!config_reg.user_trim_enable) begin
      code_out_next = code_reg;
    end else if (trimmed < 0) begin
      code_out_next = 16'h0000;
    end else if (trimmed > 18'sh0ffff) begin
      code_out_next = 16'hffff;
    end else begin
      code_out_next = trimmed[15:0];
    end
  end

  // ---------------------------------------------------------------
  // Analog and serial controls
  // ---------------------------------------------------------------
  ldrb_pkg::ldrb_analog_type analog_next;
  ldrb_pkg::ldrb_analog_type analog_reg;
  ldrb_pkg::ldrb_serial_type serial_next;
  ldrb_pkg::ldrb_serial_type serial_reg;
  logic                      range_is_current;

  always_comb begin
    range_is_current = control_reg.range[ldrb_pkg::RANGE_CURRENT_BIT];
    analog_next = '0;
    // output enable gates both stages; dual output
    analog_next.voltage_output_enable = control_reg.output_drive_enable &
      (!range_is_current | config_reg.both_outputs_enable);
    analog_next.current_output_enable = control_reg.output_drive_enable &
      (range_is_current | config_reg.both_outputs_enable);
    analog_next.voltage_range = control_reg.range;
    analog_next.current_range = config_reg.both_outputs_enable ?
      {1'b1, config_reg.current_only_range} : control_reg.range;
    analog_next.overrange_enable = control_reg.overrange_enable;
    analog_next.external_resistor_enable = control_reg.external_resistor_enable;
    analog_next.alternate_powerdown = config_reg.alternate_powerdown;
    analog_next.modulation_input_connect = config_reg.modulation_input_enable &
      analog_next.current_output_enable &
      (analog_next.current_range == ldrb_pkg::RANGE_4_TO_20);
    analog_next.slew_limit_enable = control_reg.slew_limit_enable;
    if (control_reg.slew_limit_enable) begin
      analog_next.slew_clock_select = control_reg.slew_clock_select;
      analog_next.slew_step_select  = control_reg.slew_step_select;
    end
    // chain mode; frame check and watchdog
    serial_next.chain_mode_enable  = control_reg.chain_mode_enable;
    serial_next.frame_check_enable = config_reg.frame_check_enable;
    serial_next.watchdog_enable    = config_reg.watchdog_enable;
    serial_next.watchdog_period    = config_reg.watchdog_period;
  end

  // Extra stage keeps the analog controls free of decode glitches
  // Power-on reset only; soft reset arrives a cycle later through the registers
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      analog_reg   <= '0;
      serial_reg   <= '0;
      code_out_reg <= ldrb_pkg::RESET_VALUE;
    end else begin
      analog_reg   <= analog_next;
      serial_reg   <= serial_next;
      code_out_reg <= code_out_next;
    end
  end

  assign read_word       = read_word_reg;
  assign read_word_valid = read_valid_reg;
  assign watchdog_kick   = kick_reg;
  assign output_code     = code_out_reg;
  assign analog_ctrl     = analog_reg;
  assign serial_ctrl     = serial_reg;

endmodule

// File: ldrb_register_bank_asserts.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Port checks
// ------------------------------------------------------------
module ldrb_register_bank_asserts #(
  parameter int CODE_BITS = 16
) (
  input wire logic                      clock,
  input wire logic                      sys_rst,
  input wire logic                      frame_valid,
  input wire ldrb_pkg::ldrb_frame_type  frame,
  input wire logic                      clear_value_pin,
  input wire logic                      clear_request_pin,
  input wire logic                      overtemp_pin,
  input wire logic                      current_loop_pin,
  input wire logic                      frame_check_error,
  input wire logic                      watchdog_timeout,
  input wire logic                      slewing_active,
  input wire logic [15:0]               read_word,
  input wire logic                      read_word_valid,
  input wire logic                      watchdog_kick,
  input wire logic [15:0]               output_code,
  input wire ldrb_pkg::ldrb_analog_type analog_ctrl,
  input wire ldrb_pkg::ldrb_serial_type serial_ctrl
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);

  logic rd_req;
  logic ctl_wr;
  assign rd_req = frame_valid && frame.addr == ldrb_pkg::CMD_READ;
  assign ctl_wr = frame_valid && frame.addr == ldrb_pkg::CMD_CONTROL_WR;

  read_flag_set_a: assert property (rd_req |=> read_word_valid)
    else $error("read flag not raised after read frame");
  read_flag_drop_a: assert property (frame_valid && !rd_req |=> !read_word_valid)
    else $error("read flag kept after other frame");
  kick_follow_a: assert property (frame_valid && frame.addr == 8'h95 |=> watchdog_kick)
    else $error("watchdog kick missing");
  kick_cause_a: assert property (watchdog_kick |-> $past(frame_valid && frame.addr == 8'h95))
    else $error("watchdog kick without command");
  status_upper_a: assert property (rd_req && frame.data[1:0] == 2'h0 |=> read_word[15:5] == 11'h0)
    else $error("status upper bits not zero");
  config_resv_a: assert property (rd_req && frame.data[5:0] == ldrb_pkg::RSEL_CONFIG
    |=> (read_word & ~ldrb_pkg::CONFIG_WR_MASK) == 16'h0000)
    else $error("reserved configuration bits read nonzero");
  ctrl_readback_a: assert property (ctl_wr ##1 !frame_valid ##1 rd_req && frame.data[5:0] == 6'h02
    |=> read_word == $past(frame.data, 3))
    else $error("control readback differs from write");
  out_off_a: assert property (ctl_wr && !frame.data[12]
    |-> ##2 !analog_ctrl.voltage_output_enable && !analog_ctrl.current_output_enable)
    else $error("output enabled with drive bit clear");
  slew_follow_a: assert property (ctl_wr |-> ##2 analog_ctrl.slew_limit_enable == $past(frame.data[4], 2))
    else $error("slew enable not following control");
  soft_clear_a: assert property (frame_valid && frame.addr == 8'h56 && frame.data[0]
    |-> ##4 output_code == 16'h0000 && analog_ctrl == '0 && serial_ctrl == '0)
    else $error("soft reset left outputs set");
  temp_track_a: assert property ($stable(overtemp_pin) [*8] ##1 rd_req && frame.data[5:0] == 6'h00
    |=> read_word[0] == $past(overtemp_pin))
    else $error("overtemperature bit not tracking pin");

  rd_cov: cover property (rd_req);
  kick_cov: cover property (watchdog_kick);
  cur_cov: cover property (analog_ctrl.current_output_enable);
endmodule

bind ldrb_register_bank ldrb_register_bank_asserts #(.CODE_BITS(CODE_BITS))
  ldrb_register_bank_asserts_i (
  .clock(clock), .sys_rst(sys_rst), .frame_valid(frame_valid), .frame(frame),
  .clear_value_pin(clear_value_pin), .clear_request_pin(clear_request_pin),
  .overtemp_pin(overtemp_pin), .current_loop_pin(current_loop_pin),
  .frame_check_error(frame_check_error), .watchdog_timeout(watchdog_timeout),
  .slewing_active(slewing_active), .read_word(read_word), .read_word_valid(read_word_valid),
  .watchdog_kick(watchdog_kick), .output_code(output_code), .analog_ctrl(analog_ctrl),
  .serial_ctrl(serial_ctrl));

// File: ldrb_host_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Host frame source
// ------------------------------------------------------------
module ldrb_host_model (
  input  wire logic                clock,
  output ldrb_pkg::ldrb_frame_type frame,
  output logic                     frame_valid
);
  initial begin
    frame_valid = 1'b0;
    frame       = '0;
  end

  task automatic send(input logic [7:0] addr, input logic [15:0] data);
    @(negedge clock);
    frame_valid = 1'b1;
    frame.addr  = addr;
    frame.data  = (addr == ldrb_pkg::CMD_CONFIG_WR) ? (data & ldrb_pkg::CONFIG_WR_MASK) : data;
  endtask

  // Flip lines when idle so a stale frame can never pass for a live one
  task automatic idle();
    @(negedge clock);
    frame_valid = 1'b0;
    frame       = ~frame;
  endtask
endmodule

// File: ldrb_register_bank_tb_top.sv
`timescale 1ns/1ps
module ldrb_register_bank_tb_top;
  logic                      clock;
  logic                      sys_rst;
  logic                      clear_value_pin;
  logic                      clear_request_pin;
  logic [4:0]                cause;
  logic                      frame_valid;
  ldrb_pkg::ldrb_frame_type  frame;
  logic [15:0]               read_word;
  logic                      read_word_valid;
  logic                      watchdog_kick;
  logic [15:0]               output_code;
  ldrb_pkg::ldrb_analog_type analog_ctrl;
  ldrb_pkg::ldrb_serial_type serial_ctrl;
  int                        err_total;
  int                        samples_checked;
  int                        m_ctrl, m_cfg, m_code, m_gain, m_zero;
  logic [5:0]                sels [7] = '{6'h00, 6'h01, 6'h02, 6'h0b, 6'h13, 6'h17, 6'h03};

  ldrb_host_model ldrb_host_model_i (.clock(clock), .frame(frame), .frame_valid(frame_valid));
  ldrb_register_bank #(.CODE_BITS(16)) ldrb_register_bank_i (
    .clock(clock), .sys_rst(sys_rst), .frame_valid(frame_valid), .frame(frame),
    .clear_value_pin(clear_value_pin), .clear_request_pin(clear_request_pin),
    .overtemp_pin(cause[0]),
    .current_loop_pin(cause[2]), .frame_check_error(cause[4]), .watchdog_timeout(cause[3]),
    .slewing_active(cause[1]), .read_word(read_word), .read_word_valid(read_word_valid),
    .watchdog_kick(watchdog_kick), .output_code(output_code), .analog_ctrl(analog_ctrl),
    .serial_ctrl(serial_ctrl));

  // ------------------------------------------------------------
  // Reference model
  // ------------------------------------------------------------
  function automatic int clr_val(int c);
    logic sel;
    sel = c[15] | clear_value_pin;
    if (c[2]) return 0;
    if (c[2:0] == 2 || c[2:0] == 3) return sel ? 0 : 'h8000;
    return sel ? 'h8000 : 0;
  endfunction

  function automatic int trimmed();
    longint t;
    if (!m_cfg[5]) return m_code;
    t = ((longint'(m_code) * m_gain) >>> 16) + (m_zero > 32767 ? m_zero - 65536 : m_zero);
    return t < 0 ? 0 : (t > 65535 ? 65535 : int'(t));
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("Counts: %0d mismatches in %0d checks", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // Frame tasks
  // ------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    ldrb_host_model_i.send(a, d);
    case (a)
      8'h01: m_code = d;
      8'h55: begin
        if (d[2:0] != m_ctrl[2:0]) m_code = clr_val(d);
        m_ctrl = d;
      end
      8'h57: m_cfg = d & 16'h07bf;
      8'h58: m_gain = d;
      8'h59: m_zero = d;
      8'h56: if (d[0]) begin
        {m_ctrl, m_cfg, m_code, m_gain, m_zero} = '0;
        // The frame right after a soft reset is lost, so stay idle
        ldrb_host_model_i.idle();
        repeat (2) @(negedge clock);
      end
      default: ;
    endcase
  endtask

  task automatic rd(input logic [5:0] s, input int exp);
    ldrb_host_model_i.send(8'h02, {10'h000, s});
    ldrb_host_model_i.idle();
    check({read_word_valid, read_word}, {1'b1, exp[15:0]});
  endtask

  task automatic read_all();
    int e [7];
    e = '{int'(cause), m_code, m_ctrl, m_cfg, m_gain, m_zero, 0};
    foreach (sels[i]) rd(sels[i], e[i]);
  endtask

  task automatic out_chk();
    logic        cur_en;
    logic [2:0]  cur_rng;
    logic [19:0] exp_an;
    ldrb_host_model_i.idle();
    @(negedge clock);
    cur_en  = m_ctrl[12] & (m_ctrl[2] | m_cfg[8]);
    cur_rng = m_cfg[8] ? {1'b1, m_cfg[10:9]} : m_ctrl[2:0];
    exp_an  = {m_ctrl[12] & (~m_ctrl[2] | m_cfg[8]), cur_en, m_ctrl[2:0], cur_rng, m_ctrl[14:13],
               m_cfg[7], m_cfg[4] & cur_en & (cur_rng == 3'h5), m_ctrl[4],
               m_ctrl[4] ? m_ctrl[11:5] : 7'h00};
    check(output_code, trimmed());
    check(analog_ctrl, exp_an);
    check(serial_ctrl, {m_ctrl[3], m_cfg[3:0]});
  endtask

  // ------------------------------------------------------------
  // Clock, watchdog, sequence
  // ------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  initial begin
    #200000;
    err_total++;
    tally_and_finish();
  end

  initial begin
    sys_rst = 1'b1;
    clear_value_pin = 1'b0;
    clear_request_pin = 1'b0;
    cause = '0;
    err_total = 0;
    samples_checked = 0;
    {m_ctrl, m_cfg, m_code, m_gain, m_zero} = '0;
    void'($urandom(2774));
    repeat (12) @(posedge clock);
    @(negedge clock);
    sys_rst = 1'b0;
    read_all();
    out_chk();
    repeat (20) begin
      clear_value_pin = 1'($urandom_range(0, 1));
      // Pin passes a synchroniser before the range logic sees it
      repeat (6) @(negedge clock);
      wr(8'h01, 16'($urandom));
      wr(8'h55, 16'($urandom));
      ldrb_host_model_i.idle();
      rd(6'h02, m_ctrl);
      wr(8'h57, 16'($urandom));
      wr(8'h58, 16'($urandom));
      wr(8'h59, 16'($urandom));
      out_chk();
      read_all();
    end
    // Clear request forces the clear value and blocks code writes
    clear_request_pin = 1'b1;
    repeat (6) @(negedge clock);
    wr(8'h01, 16'($urandom));
    m_code = clr_val(m_ctrl);
    out_chk();
    clear_request_pin = 1'b0;
    repeat (6) @(negedge clock);
    wr(8'h95, 16'h0000);
    ldrb_host_model_i.idle();
    check(watchdog_kick, 1'b1);
    @(negedge clock);
    check(watchdog_kick, 1'b0);
    for (int i = 0; i < 5; i++) begin
      cause[i] = 1'b1;
      repeat (8) @(negedge clock);
      rd(6'h00, 1 << i);
      cause[i] = 1'b0;
      repeat (8) @(negedge clock);
      rd(6'h00, 0);
    end
    wr(8'h56, 16'hfffe);
    read_all();
    wr(8'h56, 16'h0001);
    read_all();
    out_chk();
    tally_and_finish();
  end
endmodule
